// *** rtl/mode_regs.sv ***
// Purpose: Mode-register group of one channel: calibration inversion,
//    partial-array refresh masks, strobe oscillator count, termination
// Assumes: Commands and pins synchronous to clk_sys; one channel per instance
// Notes: One instance serves one channel; all masks are local to it
`timescale 1ns/1ns
module mode_regs (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   // Mode-register read/write command
   input wire mode_regs_pkg::mr_cmd_t mr_cmd,
   output logic [7:0] mode_reg_read_data,
   output logic mode_reg_read_valid,
   // Read calibration pattern path
   input wire logic calib_active,
   input wire logic [7:0] calib_pattern,
   output logic [15:0] calib_dq,
   output logic [1:0] calib_mask_lane,
   input wire logic bus_inversion_cfg,
   output logic bus_inversion_active,
   // Refresh gating
   input wire logic refresh_req,
   input wire logic [2:0] refresh_bank,
   input wire logic [14:0] refresh_row,
   input wire logic density_4gb,
   output logic refresh_go,
   output logic [7:0] refresh_bank_mask_out,
   output logic [7:0] refresh_segment_mask_out,
   // Strobe oscillator
   input wire logic osc_start,
   input wire logic osc_stop,
   input wire logic osc_tick,
   output logic osc_running,
   // Termination
   input wire logic cmd_term_strap,
   input wire logic [2:0] cmd_bus_term_value,
   input wire logic write_set_point_select,
   input wire logic op_set_point_select,
   output mode_regs_pkg::term_out_t term_out
);
   import mode_regs_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Register state
   ////////////////////////////////////////////////////////////////////////

   logic [7:0] calib_invert_lower_q, calib_invert_lower_d; // Lower lanes
   logic [7:0] calib_invert_upper_q, calib_invert_upper_d; // Upper lanes
   logic [7:0] refresh_bank_mask_q, refresh_bank_mask_d; // Bank mask
   logic [7:0] refresh_segment_mask_q, refresh_segment_mask_d; // Segments
   logic [4:0] term_override_q, term_override_d; // Bits 5:3 and spare
   logic [2:0] ctrl_term_sp_q [2]; // Two set-point copies
   logic [2:0] ctrl_term_sp_d [2]; // Next copies
   logic wr_hit_term; // Write to termination register

   // Write decode
   assign wr_hit_term = mr_cmd.wr && (mr_cmd.addr == ADDR_TERM_OVERRIDE);

   // Next values of the writable registers
   always_comb begin
      calib_invert_lower_d = calib_invert_lower_q;
      calib_invert_upper_d = calib_invert_upper_q;
      refresh_bank_mask_d = refresh_bank_mask_q;
      refresh_segment_mask_d = refresh_segment_mask_q;
      term_override_d = term_override_q;
      ctrl_term_sp_d = ctrl_term_sp_q;
      if (mr_cmd.wr) begin
         unique case (mr_cmd.addr)
            ADDR_CALIB_INV_LOWER: begin
               calib_invert_lower_d = mr_cmd.data;
            end
            ADDR_CALIB_INV_UPPER: begin
               calib_invert_upper_d = mr_cmd.data;
            end
            ADDR_REFRESH_BANK: begin
               refresh_bank_mask_d = mr_cmd.data;
            end
            ADDR_REFRESH_SEGMENT: begin
               // Top bits kept as written; the controller zeros them for odd densities
               refresh_segment_mask_d = mr_cmd.data;
            end
            ADDR_TERM_OVERRIDE: begin
               // Override bits and the two byte-mode bits
               term_override_d = mr_cmd.data[7:TERM_CLOCK_BIT];
            end
            default: begin
               // Other addresses hold nothing here
            end
         endcase
      end
      // Only the copy picked by the write select takes the code
      if (wr_hit_term) begin
         ctrl_term_sp_d[write_set_point_select] =
            mr_cmd.data[TERM_CODE_MSB:TERM_CODE_LSB];
      end
   end

   // Register the configuration; this instance is one channel
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         calib_invert_lower_q <= RST_CALIB_INV;
         calib_invert_upper_q <= RST_CALIB_INV;
         refresh_bank_mask_q <= RST_ZERO;
         refresh_segment_mask_q <= RST_ZERO;
         term_override_q <= '0;
         ctrl_term_sp_q[0] <= TERM_CODE_OFF;
         ctrl_term_sp_q[1] <= TERM_CODE_OFF;
      end else if (clk_en) begin
         calib_invert_lower_q <= calib_invert_lower_d;
         calib_invert_upper_q <= calib_invert_upper_d;
         refresh_bank_mask_q <= refresh_bank_mask_d;
         refresh_segment_mask_q <= refresh_segment_mask_d;
         term_override_q <= term_override_d;
         ctrl_term_sp_q <= ctrl_term_sp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Strobe oscillator count
   ////////////////////////////////////////////////////////////////////////

   osc_state_t osc_state_q, osc_state_d; // Measurement state
   logic [15:0] osc_count_q, osc_count_d; // Stored count
   logic osc_running_d; // Next running flag

   // Start clears and runs, stop freezes, ticks count while running
   always_comb begin
      osc_state_d = osc_state_q;
      osc_count_d = osc_count_q;
      if (osc_start) begin
         osc_state_d = OSC_RUN;
         osc_count_d = RST_COUNT;
      end else begin
         unique case (osc_state_q)
            OSC_IDLE: begin
               osc_state_d = OSC_IDLE;
            end
            OSC_RUN: begin
               // Saturate rather than wrap
               if (osc_tick && (osc_count_q != COUNT_MAX)) begin
                  osc_count_d = osc_count_q + 16'h0001;
               end
               if (osc_stop) begin
                  osc_state_d = OSC_DONE;
               end
            end
            OSC_DONE: begin
               osc_state_d = OSC_DONE;
            end
         endcase
      end
      osc_running_d = (osc_state_d == OSC_RUN);
   end

   // Register the oscillator state
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         osc_state_q <= OSC_IDLE;
         osc_count_q <= RST_COUNT;
         osc_running <= 1'b0;
      end else if (clk_en) begin
         osc_state_q <= osc_state_d;
         osc_count_q <= osc_count_d;
         osc_running <= osc_running_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode-register read
   ////////////////////////////////////////////////////////////////////////

   logic [7:0] rd_data_d; // Read mux
   logic rd_valid_d; // Read answer strobe

   // Only the count bytes read back; write-only and unmapped read zero
   always_comb begin
      rd_valid_d = mr_cmd.rd;
      rd_data_d = RST_ZERO;
      if (mr_cmd.rd) begin
         unique case (mr_cmd.addr)
            ADDR_OSC_COUNT_LOW: begin
               rd_data_d = osc_count_q[7:0];
            end
            ADDR_OSC_COUNT_HIGH: begin
               rd_data_d = osc_count_q[15:8];
            end
            default: begin
               rd_data_d = RST_ZERO;
            end
         endcase
      end
   end

   // Register the read answer
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg_read_data <= RST_ZERO;
         mode_reg_read_valid <= 1'b0;
      end else if (clk_en) begin
         mode_reg_read_data <= rd_data_d;
         mode_reg_read_valid <= rd_valid_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read calibration pattern
   ////////////////////////////////////////////////////////////////////////

   localparam int MASK_LANE_SRC = 0; // Pattern bit the mask lanes repeat
   logic [15:0] lane_flip; // Pattern bit of each lane after inversion
   logic [15:0] calib_dq_d; // Next lane data
   logic [1:0] mask_lane_d; // Next mask lanes
   logic bus_inversion_d; // Next bus inversion state
   logic [15:0] invert_all; // Both invert registers side by side

   assign invert_all = {calib_invert_upper_q, calib_invert_lower_q};

   // Each lane carries the pattern bit, flipped by its invert bit
   for (genvar g = 0; g < BYTES * LANES_PER_BYTE; g++) begin : g_lane
      assign lane_flip[g] = calib_pattern[g % LANES_PER_BYTE] ^ invert_all[g];
   end

   // Idle lanes show zero; mask lanes bypass the invert registers
   always_comb begin
      calib_dq_d = calib_active ? lane_flip : '0;
      // Mask lanes carry the true pattern bit, never inverted
      mask_lane_d = calib_active ? {BYTES{calib_pattern[MASK_LANE_SRC]}} : '0;
      // Bus inversion suppressed while calibrating
      bus_inversion_d = bus_inversion_cfg && !calib_active;
   end

   // Register the lanes
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         calib_dq <= '0;
         calib_mask_lane <= '0;
         bus_inversion_active <= 1'b0;
      end else if (clk_en) begin
         calib_dq <= calib_dq_d;
         calib_mask_lane <= mask_lane_d;
         bus_inversion_active <= bus_inversion_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Partial-array refresh gating
   ////////////////////////////////////////////////////////////////////////

   logic [2:0] segment_sel; // Three row bits from bit 12 (4Gb) or bit 11 (2Gb) up
   logic refresh_go_d; // Refresh allowed

   // Segment field moves up one bit for the larger density
   always_comb begin
      if (density_4gb) begin
         segment_sel = refresh_row[SEG_LSB_4GB +: 3];
      end else begin
         segment_sel = refresh_row[SEG_LSB_2GB +: 3];
      end
      refresh_go_d = refresh_req &&
         !refresh_bank_mask_q[refresh_bank] &&
         !refresh_segment_mask_q[segment_sel];
   end

   // Register refresh outputs
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         refresh_go <= 1'b0;
         refresh_bank_mask_out <= RST_ZERO;
         refresh_segment_mask_out <= RST_ZERO;
      end else if (clk_en) begin
         refresh_go <= refresh_go_d;
         refresh_bank_mask_out <= refresh_bank_mask_q;
         refresh_segment_mask_out <= refresh_segment_mask_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command-bus termination
   ////////////////////////////////////////////////////////////////////////

   term_out_t term_d; // Next termination outputs
   logic [2:0] ctrl_code_op; // Code of the operating set point
   logic bus_value_ok; // Bus value not disabled

   // Resolve overrides against the strap
   always_comb begin
      ctrl_code_op = ctrl_term_sp_q[op_set_point_select];
      bus_value_ok = (cmd_bus_term_value != TERM_CODE_OFF);
      // Reserved code treated as disabled
      term_d.ctrl_term_code = (ctrl_code_op == TERM_CODE_RSVD) ?
         TERM_CODE_OFF : ctrl_code_op;
      // Clock: override enables termination whatever the strap says, unless the bus value is off
      if (term_override_q[TERM_CLOCK_BIT - TERM_CLOCK_BIT]) begin
         term_d.clock_term_en = bus_value_ok;
      end else begin
         term_d.clock_term_en = cmd_term_strap && bus_value_ok;
      end
      // Chip select: same override scheme
      if (term_override_q[TERM_SELECT_BIT - TERM_CLOCK_BIT]) begin
         term_d.select_term_en = bus_value_ok;
      end else begin
         term_d.select_term_en = cmd_term_strap && bus_value_ok;
      end
      // Command/address: disable bit wins over strap
      if (term_override_q[TERM_CMD_DIS_BIT - TERM_CLOCK_BIT]) begin
         term_d.cmd_term_en = 1'b0;
      end else begin
         term_d.cmd_term_en = cmd_term_strap && bus_value_ok;
      end
      term_d.clock_term_value = term_d.clock_term_en ?
         cmd_bus_term_value : TERM_CODE_OFF;
      term_d.select_term_value = term_d.select_term_en ?
         cmd_bus_term_value : TERM_CODE_OFF;
      term_d.cmd_term_value = term_d.cmd_term_en ?
         cmd_bus_term_value : TERM_CODE_OFF;
   end

   // Register termination outputs
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         term_out <= '0;
      end else if (clk_en) begin
         term_out <= term_d;
      end
   end

endmodule

// *** rtl/mode_regs_pkg.sv ***
// Purpose: Shared constants and types for the mode-register group
// Assumes: 8-bit mode registers addressed by a 6-bit mode address
// Notes: One instance serves one channel
package mode_regs_pkg;

   // Mode addresses
   localparam logic [5:0] ADDR_CALIB_INV_LOWER = 6'h0F;
   localparam logic [5:0] ADDR_REFRESH_BANK = 6'h10;
   localparam logic [5:0] ADDR_REFRESH_SEGMENT = 6'h11;
   localparam logic [5:0] ADDR_OSC_COUNT_LOW = 6'h12;
   localparam logic [5:0] ADDR_OSC_COUNT_HIGH = 6'h13;
   localparam logic [5:0] ADDR_CALIB_INV_UPPER = 6'h14;
   localparam logic [5:0] ADDR_TERM_OVERRIDE = 6'h16;

   // Reset values
   localparam logic [7:0] RST_CALIB_INV = 8'h55;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;

   // Termination override field positions
   localparam int TERM_CODE_LSB = 0;
   localparam int TERM_CODE_MSB = 2;
   localparam int TERM_CLOCK_BIT = 3;
   localparam int TERM_SELECT_BIT = 4;
   localparam int TERM_CMD_DIS_BIT = 5;
   localparam logic [2:0] TERM_CODE_OFF = 3'h0;
   localparam logic [2:0] TERM_CODE_RSVD = 3'h7;

   // Lane layout of one byte with its mask lane
   localparam int LANES_PER_BYTE = 8;
   localparam int BYTES = 2;

   // Segment row bits for the two supported densities
   localparam int SEG_LSB_2GB = 11;
   localparam int SEG_LSB_4GB = 12;

   // Mode-register command from the controller
   typedef struct packed {
      logic wr;
      logic rd;
      logic [5:0] addr;
      logic [7:0] data;
   } mr_cmd_t;

   // Command-bus termination result
   typedef struct packed {
      logic clock_term_en;
      logic [2:0] clock_term_value;
      logic select_term_en;
      logic [2:0] select_term_value;
      logic cmd_term_en;
      logic [2:0] cmd_term_value;
      logic [2:0] ctrl_term_code;
   } term_out_t;

   // Oscillator measurement states
   typedef enum logic [1:0] {
      OSC_IDLE,
      OSC_RUN,
      OSC_DONE
   } osc_state_t;

endpackage

// *** verification/mode_regs_sva.sv ***
// Purpose: Port-level checks of the mode-register group
// Assumes: One clock domain; bound to every mode_regs instance
// Notes: Helper flops hold the refresh target of the previous cycle
`timescale 1ns/1ns
module mode_regs_sva (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire mode_regs_pkg::mr_cmd_t mr_cmd,
   input wire logic [7:0] mode_reg_read_data,
   input wire logic mode_reg_read_valid,
   input wire logic calib_active,
   input wire logic [7:0] calib_pattern,
   input wire logic [15:0] calib_dq,
   input wire logic [1:0] calib_mask_lane,
   input wire logic bus_inversion_cfg,
   input wire logic bus_inversion_active,
   input wire logic refresh_req,
   input wire logic [2:0] refresh_bank,
   input wire logic [14:0] refresh_row,
   input wire logic density_4gb,
   input wire logic refresh_go,
   input wire logic [7:0] refresh_bank_mask_out,
   input wire logic [7:0] refresh_segment_mask_out,
   input wire logic osc_start,
   input wire logic osc_running,
   input wire logic cmd_term_strap,
   input wire logic [2:0] cmd_bus_term_value,
   input wire mode_regs_pkg::term_out_t term_out
);
   import mode_regs_pkg::*;
   logic [2:0] seg_q; // Segment of last cycle's request
   logic [2:0] bank_q; // Bank of last cycle's request
   ////////////////////////////////////////////////////////////////////////////////
   // Refresh target one cycle back
   always_ff @(posedge clk_sys) begin
      seg_q <= density_4gb ? refresh_row[14:12] : refresh_row[13:11];
      bank_q <= refresh_bank;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Read accepted at an enabled edge
   sequence s_rd_taken;
      clk_en && mr_cmd.rd;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_read_valid: assert property (clk_en |=> mode_reg_read_valid == $past(mr_cmd.rd))
      else $error("read valid not one cycle after read");
   a_wo_read_zero: assert property (s_rd_taken ##0 mr_cmd.addr[5:1] != 5'h09 |=>
      mode_reg_read_data == 8'h00) else $error("write-only read not zero");
   a_mask_lanes: assert property (clk_en |=> calib_mask_lane ==
      ($past(calib_active) ? {2{$past(calib_pattern[0])}} : 2'h0))
      else $error("mask lane not true pattern");
   a_calib_no_inv: assert property (clk_en && calib_active |=> !bus_inversion_active)
      else $error("bus inversion during calibration");
   a_inv_follow: assert property (clk_en && !calib_active |=>
      bus_inversion_active == $past(bus_inversion_cfg)) else $error("bus inversion wrong");
   a_dq_idle: assert property (clk_en && !calib_active |=> calib_dq == 16'h0000)
      else $error("calibration lanes active outside calibration");
   a_refresh_gate: assert property (clk_en && refresh_req |=> refresh_go ==
      !(refresh_bank_mask_out[bank_q] || refresh_segment_mask_out[seg_q]))
      else $error("refresh gating wrong");
   a_osc_start: assert property (clk_en && osc_start |=> osc_running)
      else $error("oscillator not running after start");
   a_cmd_term: assert property (clk_en && !(cmd_term_strap && cmd_bus_term_value != 3'h0)
      |=> !term_out.cmd_term_en) else $error("command termination without strap");
   a_term_value: assert property (clk_en |=> term_out.clock_term_value ==
      (term_out.clock_term_en ? $past(cmd_bus_term_value) : 3'h0))
      else $error("clock termination value wrong");
   a_code_rsvd: assert property (term_out.ctrl_term_code != TERM_CODE_RSVD)
      else $error("reserved termination code shown");
endmodule

// *** verification/mr_ctrl.sv ***
// Purpose: Controller model issuing mode-register writes and reads
// Assumes: Commands launched just after a rising edge, one cycle each
// Notes: Idle payload is inverted so stale fields never look valid
`timescale 1ns/1ns
module mr_ctrl (
   input wire logic clk_sys,
   output mode_regs_pkg::mr_cmd_t mr_cmd,
   input wire logic [7:0] mode_reg_read_data,
   input wire logic mode_reg_read_valid
);
   import mode_regs_pkg::*;
   initial mr_cmd = '0;
   ////////////////////////////////////////////////////////////////////////////////
   // Release the bus
   task automatic idle();
      mr_cmd <= {1'b0, 1'b0, ~mr_cmd.addr, ~mr_cmd.data};
   endtask
   // One write cycle
   task automatic mode_reg_write(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      mr_cmd <= {1'b1, 1'b0, a, d};
      @(posedge clk_sys);
      idle();
   endtask
   // One read, bounded wait for valid; X if it never comes
   task automatic mode_reg_read(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      mr_cmd <= {1'b0, 1'b1, a, ~mr_cmd.data};
      @(posedge clk_sys);
      idle();
      d = 8'hXX;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         if (mode_reg_read_valid === 1'b1) begin
            d = mode_reg_read_data;
            break;
         end
      end
   endtask
   // Both count bytes joined, high byte first; usable for strobe phase tuning
   task automatic read_count(output logic [15:0] c);
      logic [7:0] hi;
      logic [7:0] lo;
      mode_reg_read(ADDR_OSC_COUNT_HIGH, hi);
      mode_reg_read(ADDR_OSC_COUNT_LOW, lo);
      c = {hi, lo};
   endtask
   // Odd densities keep the top two segment bits low
   task automatic mrw_segment(input logic [7:0] m, input logic odd);
      mode_reg_write(ADDR_REFRESH_SEGMENT, odd ? {2'b00, m[5:0]} : m);
   endtask
endmodule

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for the mode-register group
// Assumes: clk_en held high; controller model drives the command bus
// Notes: Inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ns
module tb_top;
   import mode_regs_pkg::*;
   logic clk_sys, reset_n, clk_en, calib_active, bus_inversion_cfg, bus_inversion_active;
   logic refresh_req, density_4gb, refresh_go, osc_start, osc_stop, osc_tick, osc_running;
   logic cmd_term_strap, write_set_point_select, op_set_point_select, mode_reg_read_valid;
   logic [7:0] calib_pattern, mode_reg_read_data, refresh_bank_mask_out;
   logic [7:0] refresh_segment_mask_out;
   logic [15:0] calib_dq;
   logic [1:0] calib_mask_lane;
   logic [2:0] refresh_bank, cmd_bus_term_value;
   logic [14:0] refresh_row;
   mr_cmd_t mr_cmd;
   term_out_t term_out;
   int n_errors = 0;
   int compares = 0;
   mode_regs u_dut (.*);
   mr_ctrl u_ctrl (.*);
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // Compare one result
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Let one edge land, look at the falling edge
   task automatic settle();
      @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic results();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [7:0] d;
      u_ctrl.mode_reg_read(ADDR_TERM_OVERRIDE, d);
      chk("write-only read", 16'h0000, {8'h00, d});
      u_ctrl.mode_reg_read(6'h3F, d);
      chk("unmapped read", 16'h0000, {8'h00, d});
      @(posedge clk_sys);
      calib_active <= 1'b1;
      calib_pattern <= 8'hFF;
      settle();
      chk("reset invert", 16'hAAAA, calib_dq);
      $display("t_reset done");
   endtask
   task automatic t_calib();
      u_ctrl.mode_reg_write(ADDR_CALIB_INV_LOWER, 8'h15);
      u_ctrl.mode_reg_write(ADDR_CALIB_INV_UPPER, 8'hA3);
      @(posedge clk_sys);
      calib_pattern <= 8'h0F;
      bus_inversion_cfg <= 1'b1;
      settle();
      chk("calib dq", 16'hAC1A, calib_dq);
      chk("mask lanes", 16'h0003, {14'h0, calib_mask_lane});
      chk("inversion in calib", 16'h0000, {15'h0, bus_inversion_active});
      @(posedge clk_sys);
      calib_active <= 1'b0;
      settle();
      chk("idle dq", 16'h0000, calib_dq);
      chk("inversion idle", 16'h0001, {15'h0, bus_inversion_active});
      $display("t_calib done");
   endtask
   task automatic t_refresh();
      logic [16:0] rows [4] = '{{1'b0, 15'h1000, 1'b0}, {1'b1, 15'h1000, 1'b1},
         {1'b1, 15'h2000, 1'b0}, {1'b0, 15'h3800, 1'b1}};
      u_ctrl.mode_reg_write(ADDR_REFRESH_BANK, 8'h81);
      u_ctrl.mrw_segment(8'hC4, 1'b1);
      for (int b = 0; b < 8; b++) begin
         @(posedge clk_sys);
         refresh_req <= 1'b1;
         refresh_bank <= b[2:0];
         refresh_row <= 15'h0000;
         settle();
         chk("bank go", {15'h0, !(b == 0 || b == 7)}, {15'h0, refresh_go});
      end
      chk("bank mask out", 16'h0081, {8'h00, refresh_bank_mask_out});
      chk("segment mask out", 16'h0004, {8'h00, refresh_segment_mask_out});
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         refresh_bank <= 3'h1;
         {density_4gb, refresh_row} <= rows[i][16:1];
         settle();
         chk("segment go", {15'h0, rows[i][0]}, {15'h0, refresh_go});
      end
      $display("t_refresh done");
   endtask
   task automatic t_osc();
      logic [15:0] c;
      @(posedge clk_sys);
      osc_start <= 1'b1;
      osc_tick <= 1'b1;
      @(posedge clk_sys);
      osc_start <= 1'b0;
      @(negedge clk_sys);
      chk("running", 16'h0001, {15'h0, osc_running});
      repeat (299) @(posedge clk_sys);
      osc_tick <= 1'b0;
      osc_stop <= 1'b1;
      @(posedge clk_sys);
      osc_stop <= 1'b0;
      @(negedge clk_sys);
      chk("stopped", 16'h0000, {15'h0, osc_running});
      u_ctrl.read_count(c);
      chk("count", 16'h012B, c);
      @(posedge clk_sys);
      osc_start <= 1'b1;
      @(posedge clk_sys);
      osc_start <= 1'b0;
      u_ctrl.read_count(c);
      chk("restart count", 16'h0000, c);
      $display("t_osc done");
   endtask
   task automatic t_term();
      logic [19:0] tab [6] = '{{2'b00, 8'h01, 1'b1, 3'h3, 3'b111, 3'h1},
         {2'b00, 8'h02, 1'b0, 3'h3, 3'b000, 3'h2}, {2'b00, 8'h0E, 1'b0, 3'h5, 3'b100, 3'h6},
         {2'b00, 8'h37, 1'b0, 3'h2, 3'b010, 3'h0}, {2'b10, 8'h23, 1'b1, 3'h4, 3'b110, 3'h0},
         {2'b01, 8'h04, 1'b1, 3'h4, 3'b111, 3'h3}};
      term_out_t e;
      logic [2:0] v;
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_sys);
         {write_set_point_select, op_set_point_select} <= tab[i][19:18];
         {cmd_term_strap, cmd_bus_term_value} <= tab[i][9:6];
         u_ctrl.mode_reg_write(ADDR_TERM_OVERRIDE, tab[i][17:10]);
         settle();
         v = tab[i][8:6];
         e = {tab[i][5], tab[i][5] ? v : 3'h0, tab[i][4], tab[i][4] ? v : 3'h0,
            tab[i][3], tab[i][3] ? v : 3'h0, tab[i][2:0]};
         chk("term out", {1'b0, e}, {1'b0, term_out});
      end
      $display("t_term done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {clk_en, reset_n, calib_active, calib_pattern, bus_inversion_cfg} = '0;
      {refresh_req, refresh_bank, refresh_row, density_4gb} = '0;
      {osc_start, osc_stop, osc_tick, cmd_term_strap, cmd_bus_term_value} = '0;
      {write_set_point_select, op_set_point_select} = '0;
      clk_en = 1'b1;
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_reset();
      t_calib();
      t_refresh();
      t_osc();
      t_term();
      results();
   end
   // Hang guard
   initial begin
      #400000;
      n_errors++;
      $display("ERROR watchdog expected finish seen hang");
      results();
   end
endmodule
bind mode_regs mode_regs_sva u_sva (.*);
